/* File: verilog/idum_pkg.sv */
// constants and types shared by the incident data uplink modulator
`default_nettype none
package idum_pkg;
  // record and coded buffer geometry
  localparam int IDUM_REC_BITS = 1148;
  localparam int IDUM_TAIL_BITS = 3;
  localparam int IDUM_TAIL1_OFS = 1148;
  localparam int IDUM_TAIL2_OFS = 1151;
  localparam int IDUM_PAR1_OFS = 1154;
  localparam int IDUM_PTAIL1_OFS = 2302;
  localparam int IDUM_PAR2_OFS = 2305;
  localparam int IDUM_PTAIL2_OFS = 3453;
  localparam int IDUM_CODED_BITS = 3456;
  localparam int IDUM_RV_BITS = 1380;
  localparam int IDUM_SYM_BITS = 3;
  // sample timing
  localparam int IDUM_SAMPLE_RATE_HZ = 8000;
  localparam int IDUM_SPEECH_FRAME_MS = 20;
  localparam int IDUM_SPF_SMP = IDUM_SPEECH_FRAME_MS * IDUM_SAMPLE_RATE_HZ / 1000;
  localparam int IDUM_MF_SMP_FAST = 16;
  localparam int IDUM_MF_SMP_ROBUST = 32;
  localparam int IDUM_MF_PER_SF_FAST = IDUM_SPF_SMP / IDUM_MF_SMP_FAST;
  localparam int IDUM_MF_PER_SF_ROBUST = IDUM_SPF_SMP / IDUM_MF_SMP_ROBUST;
  // sync fragment: leading zeros, then the preamble's last samples
  localparam int IDUM_SYNC_ZERO_SMP = 64;
  localparam int IDUM_SYNC_TAIL_SMP = 576;
  localparam int IDUM_PREAMBLE_SMP = 1568;
  localparam int IDUM_SYNC_BASE = IDUM_PREAMBLE_SMP - IDUM_SYNC_TAIL_SMP;
  // data frame layout
  localparam int IDUM_N_SLOTS = 10;
  typedef enum logic [1:0] {IDUM_MUTE, IDUM_DATA, IDUM_SYNC} idum_slot_t;
  localparam idum_slot_t IDUM_SLOT_KIND [IDUM_N_SLOTS] = '{IDUM_MUTE, IDUM_DATA, IDUM_SYNC,
    IDUM_MUTE, IDUM_DATA, IDUM_SYNC, IDUM_MUTE, IDUM_DATA, IDUM_SYNC, IDUM_MUTE};
  localparam logic [5:0] IDUM_SLOT_FR_FAST [IDUM_N_SLOTS] = '{6'h01, 6'h0F, 6'h04, 6'h02,
    6'h0F, 6'h04, 6'h02, 6'h10, 6'h04, 6'h03};
  localparam logic [5:0] IDUM_SLOT_FR_ROBUST [IDUM_N_SLOTS] = '{6'h01, 6'h1E, 6'h04, 6'h04,
    6'h1E, 6'h04, 6'h04, 6'h20, 6'h04, 6'h03};
  // fast-mode base pulse
  localparam logic signed [15:0] IDUM_PULSE_FAST [IDUM_MF_SMP_FAST] = '{16'sh0000,
    16'sh0000, 16'sh0000, 16'sh0028, -16'sh00C8, 16'sh0230, -16'sh03DF, -16'sh0578,
    16'sh1DD4, 16'sh3A98, 16'sh1DD4, -16'sh0578, -16'sh03DF, 16'sh0230, -16'sh00C8,
    16'sh0028};
  // sequencer states
  typedef enum logic [3:0] {IDUM_S_LOAD, IDUM_S_ENC_A, IDUM_S_ENC_B, IDUM_S_TAIL,
    IDUM_S_READY, IDUM_S_PREP, IDUM_S_FETCH_A, IDUM_S_FETCH_B, IDUM_S_PUSH} idum_state_t;
endpackage : idum_pkg
`default_nettype wire

/* File: verilog/idum_fifo.sv */
// small valid/ready fifo for output samples
`default_nettype none
module idum_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW-1:0] wr_ptr_ff; // write slot
  logic [AW-1:0] rd_ptr_ff; // read slot
  logic [AW:0] cnt_ff; // words held
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW-1:0] wr_nxt = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [AW-1:0] rd_nxt = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
  assign in_ready_o = (cnt_ff != (AW + 1)'(DEPTH)); // honest full
  assign out_valid_o = (cnt_ff != '0); // honest empty
  assign out_data_o = mem[rd_ptr_ff];
  ////////////////////////////////////////////////////////////////////////////
  // storage write
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end
  // pointers and occupancy
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push) wr_ptr_ff <= wr_nxt;
      if (pop) rd_ptr_ff <= rd_nxt;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : idum_fifo
`default_nettype wire

/* File: verilog/idum_modulator.sv */
// encoder, redundancy selector, pulse modulator and frame multiplexer
`default_nettype none
module idum_modulator
  import idum_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter logic signed [15:0] ROBUST_PULSE [IDUM_MF_SMP_ROBUST] = '{default: 16'sh0000}
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic rec_valid_i, // record bit offered
  input wire logic rec_bit_i, // record bit, index 0 first
  input wire logic scr_bit_i, // scramble bit paired with rec_bit_i
  output logic rec_ready_o, // loading record
  output logic [10:0] il_addr_o, // interleaver table address
  input wire logic [10:0] il_idx_i, // interleaved source index
  output logic [13:0] rv_addr_o, // {version, selection index}
  input wire logic [11:0] rv_pos_i, // coded buffer position
  output logic [10:0] sync_addr_o, // preamble sample address
  input wire logic signed [15:0] sync_smp_i, // preamble sample
  input wire logic start_i, // send one data frame
  input wire logic [2:0] rv_i, // redundancy version for start_i
  input wire logic robust_i, // robust mode for start_i
  input wire logic smp_stb_i, // 8 kHz sample strobe
  output logic signed [15:0] sample_o, // coder input sample
  output logic coded_ready_o, // coded buffer filled, idle
  output logic busy_o, // data frame in progress
  output logic frame_done_o, // last sample of frame queued
  output logic underrun_o // strobe found no sample
);
  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  idum_state_t state_ff; // sequencer state
  idum_state_t nxt_state; // next sequencer state
  logic scr_mem [IDUM_REC_BITS]; // scrambled record
  logic coded_mem [IDUM_CODED_BITS]; // coded bit buffer
  logic [10:0] cnt_ff; // load / encode bit index
  logic [2:0] tail_ff; // tail step 0..5
  logic [2:0] enc1_ff; // first encoder register
  logic [2:0] enc2_ff; // second encoder register
  logic [2:0] rv_ff; // latched version
  logic robust_ff; // latched mode
  logic [3:0] slot_ff; // slot in data frame
  logic [12:0] slot_smp_ff; // sample within slot
  logic [4:0] mf_smp_ff; // sample within modulation frame
  logic [10:0] sel_ff; // selected bit index
  logic [1:0] bit_ff; // bit within symbol
  logic [2:0] sym_ff; // current symbol
  logic rec_ready_ff; // registered load ready
  logic [10:0] il_addr_ff; // interleaver address
  logic [13:0] rv_addr_ff; // version table address
  logic [10:0] sync_addr_ff; // preamble address
  logic signed [15:0] sample_ff; // output sample
  logic coded_ready_ff; // idle with buffer ready
  logic busy_ff; // frame running
  logic done_ff; // frame finished pulse
  logic underrun_ff; // missing sample pulse
  ////////////////////////////////////////////////////////////////////////////
  // constituent encoder step: feedback 1+D^2+D^3, parity 1+D+D^3
  function automatic logic [3:0] idum_enc_step(input logic u, input logic [2:0] r);
    logic fb;
    fb = u ^ r[1] ^ r[2];
    idum_enc_step = {fb ^ r[0] ^ r[2], r[1], r[0], fb};
  endfunction : idum_enc_step
  ////////////////////////////////////////////////////////////////////////////
  // decode of load and encode progress
  wire load_take = (state_ff == IDUM_S_LOAD) & rec_valid_i & rec_ready_ff;
  wire last_bit = (cnt_ff == 11'(IDUM_REC_BITS - 1));
  wire u_sys = scr_mem[cnt_ff]; // natural order
  wire u_il = scr_mem[il_idx_i]; // permuted order
  wire [3:0] step1 = idum_enc_step(u_sys, enc1_ff);
  wire [3:0] step2 = idum_enc_step(u_il, enc2_ff);
  wire tail_first = (tail_ff < 3'(IDUM_TAIL_BITS)); // first encoder tails
  wire tu1 = enc1_ff[1] ^ enc1_ff[2]; // feedback cancels input
  wire tu2 = enc2_ff[1] ^ enc2_ff[2];
  wire tp1 = enc1_ff[0] ^ enc1_ff[2]; // tail parity
  wire tp2 = enc2_ff[0] ^ enc2_ff[2];
  wire [1:0] tail_idx = tail_first ? tail_ff[1:0] : 2'(tail_ff - 3'(IDUM_TAIL_BITS));
  ////////////////////////////////////////////////////////////////////////////
  // decode of frame layout
  idum_slot_t slot_kind;
  assign slot_kind = IDUM_SLOT_KIND[slot_ff];
  wire [5:0] slot_fr = robust_ff ? IDUM_SLOT_FR_ROBUST[slot_ff] : IDUM_SLOT_FR_FAST[slot_ff];
  wire [12:0] slot_len = 13'(slot_fr * IDUM_SPF_SMP);
  wire slot_end = (slot_smp_ff == slot_len - 13'h0001);
  wire frame_end = slot_end & (slot_ff == 4'(IDUM_N_SLOTS - 1));
  wire [4:0] mf_len = robust_ff ? 5'(IDUM_MF_SMP_ROBUST - 1) : 5'(IDUM_MF_SMP_FAST - 1);
  wire mf_end = (mf_smp_ff == mf_len);
  wire sync_zero = (slot_smp_ff < 13'(IDUM_SYNC_ZERO_SMP));
  wire [12:0] sync_rel = slot_smp_ff - 13'(IDUM_SYNC_ZERO_SMP);
  ////////////////////////////////////////////////////////////////////////////
  // symbol to waveform sample
  wire [1:0] sym_pos = sym_ff[2] ? ~sym_ff[1:0] : sym_ff[1:0]; // reversed shifts
  wire [3:0] k_fast = {sym_pos, 2'b00}; // steps of 4
  wire [4:0] k_robust = {sym_pos, 3'b000}; // steps of 8
  wire [3:0] idx_fast = mf_smp_ff[3:0] - k_fast; // cyclic right shift
  wire [4:0] idx_robust = mf_smp_ff - k_robust;
  wire signed [15:0] base_smp = robust_ff ? ROBUST_PULSE[idx_robust]
                                          : IDUM_PULSE_FAST[idx_fast];
  wire signed [15:0] data_smp = sym_ff[2] ? -base_smp : base_smp; // sign q
  logic signed [15:0] gen_smp; // sample offered to fifo
  always_comb
  begin
    unique case (slot_kind)
      IDUM_DATA: gen_smp = data_smp;
      IDUM_SYNC: gen_smp = sync_zero ? 16'sh0000 : sync_smp_i;
      default: gen_smp = 16'sh0000; // muting gap
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // output fifo
  wire fifo_in_valid = (state_ff == IDUM_S_PUSH);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire fifo_pop = smp_stb_i & fifo_out_valid; // one sample per strobe
  wire push_ok = fifo_in_valid & fifo_in_ready; // stall while full
  idum_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(gen_smp),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(smp_stb_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      IDUM_S_LOAD: if (load_take && last_bit) nxt_state = IDUM_S_ENC_A;
      IDUM_S_ENC_A: nxt_state = IDUM_S_ENC_B;
      IDUM_S_ENC_B: nxt_state = last_bit ? IDUM_S_TAIL : IDUM_S_ENC_A;
      IDUM_S_TAIL: if (tail_ff == 3'(2 * IDUM_TAIL_BITS - 1)) nxt_state = IDUM_S_READY;
      IDUM_S_READY: if (start_i) nxt_state = IDUM_S_PREP;
      IDUM_S_PREP:
        if (slot_kind == IDUM_DATA && mf_smp_ff == 5'h00) nxt_state = IDUM_S_FETCH_A;
        else nxt_state = IDUM_S_PUSH;
      IDUM_S_FETCH_A: nxt_state = IDUM_S_FETCH_B;
      IDUM_S_FETCH_B: nxt_state = (bit_ff == 2'(IDUM_SYM_BITS - 1)) ? IDUM_S_PUSH
                                                                 : IDUM_S_FETCH_A;
      IDUM_S_PUSH:
        if (push_ok) nxt_state = frame_end ? IDUM_S_READY : IDUM_S_PREP;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i) state_ff <= IDUM_S_LOAD;
    else state_ff <= nxt_state;
  end
  // scrambled record store
  always_ff @(posedge clk_sys_i)
  begin
    if (load_take) scr_mem[cnt_ff] <= rec_bit_i ^ scr_bit_i;
  end
  // coded buffer store, layout fixed by offsets
  always_ff @(posedge clk_sys_i)
  begin
    if (state_ff == IDUM_S_ENC_B)
    begin
      coded_mem[cnt_ff] <= u_sys; // systematic
      coded_mem[12'(IDUM_PAR1_OFS) + 12'(cnt_ff)] <= step1[3];
      coded_mem[12'(IDUM_PAR2_OFS) + 12'(cnt_ff)] <= step2[3];
    end
    else if (state_ff == IDUM_S_TAIL && tail_first)
    begin
      coded_mem[12'(IDUM_TAIL1_OFS) + 12'(tail_idx)] <= tu1;
      coded_mem[12'(IDUM_PTAIL1_OFS) + 12'(tail_idx)] <= tp1;
    end
    else if (state_ff == IDUM_S_TAIL)
    begin
      coded_mem[12'(IDUM_TAIL2_OFS) + 12'(tail_idx)] <= tu2;
      coded_mem[12'(IDUM_PTAIL2_OFS) + 12'(tail_idx)] <= tp2;
    end
  end
  // bit index for load and encode
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i) cnt_ff <= '0;
    else if (load_take) cnt_ff <= last_bit ? '0 : cnt_ff + 11'h001;
    else if (state_ff == IDUM_S_ENC_B) cnt_ff <= last_bit ? '0 : cnt_ff + 11'h001;
  end
  // encoder registers: cleared while loading, tails only move one side
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      enc1_ff <= '0;
      enc2_ff <= '0;
      tail_ff <= '0;
    end
    else if (state_ff == IDUM_S_LOAD)
    begin
      enc1_ff <= '0;
      enc2_ff <= '0;
      tail_ff <= '0;
    end
    else if (state_ff == IDUM_S_ENC_B)
    begin
      enc1_ff <= step1[2:0];
      enc2_ff <= step2[2:0];
    end
    else if (state_ff == IDUM_S_TAIL)
    begin
      tail_ff <= tail_ff + 3'h1;
      if (tail_first) enc1_ff <= {enc1_ff[1:0], 1'b0}; // second held
      else enc2_ff <= {enc2_ff[1:0], 1'b0}; // first held
    end
  end
  // frame parameters latched at start
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rv_ff <= '0;
      robust_ff <= 1'b0;
    end
    else if (state_ff == IDUM_S_READY && start_i)
    begin
      rv_ff <= rv_i;
      robust_ff <= robust_i; // held for frame
    end
  end
  // slot and sample position
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      slot_ff <= '0;
      slot_smp_ff <= '0;
      mf_smp_ff <= '0;
    end
    else if (state_ff == IDUM_S_READY)
    begin
      slot_ff <= '0;
      slot_smp_ff <= '0;
      mf_smp_ff <= '0;
    end
    else if (push_ok)
    begin
      slot_smp_ff <= slot_end ? '0 : slot_smp_ff + 13'h0001;
      slot_ff <= slot_end ? slot_ff + 4'h1 : slot_ff;
      mf_smp_ff <= (mf_end || slot_end) ? '0 : mf_smp_ff + 5'h01;
    end
  end
  // symbol assembly from selected bits
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sel_ff <= '0;
      bit_ff <= '0;
      sym_ff <= '0;
    end
    else if (state_ff == IDUM_S_READY)
    begin
      sel_ff <= '0;
      bit_ff <= '0;
    end
    else if (state_ff == IDUM_S_FETCH_B)
    begin
      sym_ff <= {sym_ff[1:0], coded_mem[rv_pos_i]}; // first bit lands msb
      sel_ff <= sel_ff + 11'h001;
      bit_ff <= (bit_ff == 2'(IDUM_SYM_BITS - 1)) ? 2'b00 : bit_ff + 2'b01;
    end
  end
  // table addresses
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      il_addr_ff <= '0;
      rv_addr_ff <= '0;
      sync_addr_ff <= '0;
    end
    else
    begin
      if (state_ff == IDUM_S_ENC_A) il_addr_ff <= cnt_ff;
      if (state_ff == IDUM_S_FETCH_A) rv_addr_ff <= {rv_ff, sel_ff};
      if (state_ff == IDUM_S_PREP) sync_addr_ff <= 11'(IDUM_SYNC_BASE) + sync_rel[10:0];
    end
  end
  // status outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rec_ready_ff <= 1'b0;
      coded_ready_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      rec_ready_ff <= (nxt_state == IDUM_S_LOAD);
      coded_ready_ff <= (nxt_state == IDUM_S_READY);
      busy_ff <= (nxt_state inside {IDUM_S_PREP, IDUM_S_FETCH_A, IDUM_S_FETCH_B,
        IDUM_S_PUSH});
      done_ff <= push_ok & frame_end;
    end
  end
  // sample output, zero when nothing queued
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sample_ff <= '0;
      underrun_ff <= 1'b0;
    end
    else
    begin
      if (smp_stb_i) sample_ff <= fifo_pop ? fifo_out_data : 16'sh0000;
      underrun_ff <= smp_stb_i & ~fifo_out_valid & busy_ff;
    end
  end
  assign rec_ready_o = rec_ready_ff;
  assign il_addr_o = il_addr_ff;
  assign rv_addr_o = rv_addr_ff;
  assign sync_addr_o = sync_addr_ff;
  assign sample_o = sample_ff;
  assign coded_ready_o = coded_ready_ff;
  assign busy_o = busy_ff;
  assign frame_done_o = done_ff;
  assign underrun_o = underrun_ff;
endmodule : idum_modulator
`default_nettype wire

/* File: tb/idum_coder_model.sv */
// speech coder input model: sample strobe source of the voice channel
`default_nettype none
module idum_coder_model #(
  parameter int PERIOD = 6
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  output logic smp_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff; // cycles within one sample period
  logic [7:0] nxt_cnt;
  logic wrap; // last cycle of the period
  assign wrap = (cnt_ff == 8'(PERIOD - 1));
  assign nxt_cnt = wrap ? 8'h00 : cnt_ff + 8'h01;
  // one single-cycle strobe per sample period, only while enabled
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_ff <= 8'h00;
      smp_stb_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      smp_stb_o <= en_i && wrap;
    end
  end
endmodule : idum_coder_model
`default_nettype wire

/* File: tb/idum_modulator_asserts.sv */
// port checker for the incident data uplink modulator
`default_nettype none
module idum_modulator_asserts
  import idum_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic rec_valid_i,
  input wire logic rec_ready_o,
  input wire logic start_i,
  input wire logic smp_stb_i,
  input wire logic [13:0] rv_addr_o,
  input wire logic signed [15:0] sample_o,
  input wire logic coded_ready_o,
  input wire logic busy_o,
  input wire logic frame_done_o,
  input wire logic underrun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] bit_cnt_ff; // record bits taken so far
  logic [10:0] nxt_bit_cnt;
  assign nxt_bit_cnt = (rec_valid_i && rec_ready_o) ? bit_cnt_ff + 11'h001 : bit_cnt_ff;
  // count taken record bits
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bit_cnt_ff <= 11'h000;
    else
      bit_cnt_ff <= nxt_bit_cnt;
  end
  default clocking main_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take_last;
    rec_valid_i && rec_ready_o && (bit_cnt_ff == 11'h47B);
  endsequence
  sequence s_load_closed;
    !rec_ready_o [*2];
  endsequence
  sequence s_start_taken;
    start_i && coded_ready_o;
  endsequence
  sequence s_frame_on;
    busy_o && !coded_ready_o;
  endsequence
  AST_READY_RESET: assert property ($rose(arst_n_i) |=> rec_ready_o)
    else $error("record input not ready after reset");
  AST_LOAD_END: assert property (s_take_last |=> s_load_closed)
    else $error("record input still ready after last bit");
  AST_LOAD_COUNT: assert property ($fell(rec_ready_o) |-> bit_cnt_ff == 11'h47C)
    else $error("record load closed at wrong bit count");
  AST_START_BUSY: assert property (s_start_taken |=> s_frame_on)
    else $error("start not followed by busy");
  AST_BUSY_CAUSE: assert property ($rose(busy_o)
    |-> $past(start_i) && $past(coded_ready_o))
    else $error("busy without an accepted start");
  AST_BUSY_EXCL: assert property (busy_o |-> !coded_ready_o)
    else $error("busy and ready together");
  AST_SAMPLE_HOLD: assert property (!smp_stb_i |=> $stable(sample_o))
    else $error("sample changed without strobe");
  AST_LOAD_SILENT: assert property (rec_ready_o && smp_stb_i |=> sample_o == 16'sh0000)
    else $error("nonzero sample while loading");
  AST_DONE_PULSE: assert property (frame_done_o
    |-> !busy_o && coded_ready_o ##1 !frame_done_o)
    else $error("frame done not a single pulse at frame end");
  AST_UNDERRUN_CAUSE: assert property (underrun_o
    |-> $past(smp_stb_i) && sample_o == 16'sh0000)
    else $error("underrun without strobe");
  AST_RV_STEP: assert property (busy_o && $changed(rv_addr_o[10:0])
    |-> rv_addr_o[10:0] == $past(rv_addr_o[10:0]) + 11'h001 || rv_addr_o[10:0] == 11'h000)
    else $error("version selection index skipped");
endmodule : idum_modulator_asserts
bind idum_modulator idum_modulator_asserts u_asserts (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .rec_valid_i(rec_valid_i), .rec_ready_o(rec_ready_o),
  .start_i(start_i), .smp_stb_i(smp_stb_i), .rv_addr_o(rv_addr_o), .sample_o(sample_o),
  .coded_ready_o(coded_ready_o), .busy_o(busy_o), .frame_done_o(frame_done_o),
  .underrun_o(underrun_o));
`default_nettype wire

/* File: tb/incident_data_uplink_modulator_bench.sv */
// self-checking bench: one random record sent as a fast then a robust data frame
`default_nettype none
module incident_data_uplink_modulator_bench
  import idum_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic rec_valid_i = 1'b0, rec_bit_i = 1'b0, scr_bit_i = 1'b0, rec_ready_o;
  logic [10:0] il_addr_o, il_idx_i, sync_addr_o;
  logic [13:0] rv_addr_o;
  logic [11:0] rv_pos_i;
  logic signed [15:0] sync_smp_i, sample_o;
  logic start_i = 1'b0, robust_i = 1'b0, smp_stb_i, en = 1'b0;
  logic [2:0] rv_i = 3'h0;
  logic coded_ready_o, busy_o, frame_done_o, underrun_o;
  int n_fail = 0, comparisons = 0, n_under = 0, n_done = 0, seed = 37729;
  logic rec [1148]; // plain record bits
  logic scr [1148]; // scramble bits
  logic sb [1148]; // scrambled bits
  logic cb [3456]; // expected coded buffer
  logic signed [15:0] expq [$]; // expected samples
  logic [1:0] kq [$]; // slot kind of each expected sample
  always #2 clk_sys_i = ~clk_sys_i;
  // stand-in tables: permutation, version positions, preamble
  function automatic logic [10:0] il_fn(input logic [10:0] i);
    return 11'((int'(i) * 13) % 1148);
  endfunction : il_fn
  function automatic logic [11:0] rv_fn(input logic [2:0] v, input logic [10:0] s);
    if (!v[0] && s < 11'h47C)
      return 12'(s);
    return v[0] ? 12'((int'(s) * 5 + int'(v)) % 3456) : 12'(1148 + (int'(s) * 9) % 2308);
  endfunction : rv_fn
  function automatic logic signed [15:0] sync_fn(input logic [10:0] a);
    return {a, a[4:0]};
  endfunction : sync_fn
  assign il_idx_i = il_fn(il_addr_o);
  assign rv_pos_i = rv_fn(rv_addr_o[13:11], rv_addr_o[10:0]);
  assign sync_smp_i = sync_fn(sync_addr_o);
  ////////////////////////////////////////////////////////////////////////////
  idum_modulator dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .rec_valid_i(rec_valid_i),
    .rec_bit_i(rec_bit_i), .scr_bit_i(scr_bit_i), .rec_ready_o(rec_ready_o),
    .il_addr_o(il_addr_o), .il_idx_i(il_idx_i), .rv_addr_o(rv_addr_o), .rv_pos_i(rv_pos_i),
    .sync_addr_o(sync_addr_o), .sync_smp_i(sync_smp_i), .start_i(start_i), .rv_i(rv_i),
    .robust_i(robust_i), .smp_stb_i(smp_stb_i), .sample_o(sample_o),
    .coded_ready_o(coded_ready_o), .busy_o(busy_o), .frame_done_o(frame_done_o),
    .underrun_o(underrun_o));
  idum_coder_model #(.PERIOD(3)) part_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .en_i(en),
    .smp_stb_o(smp_stb_i));
  // count pulses seen on the status outputs
  always @(posedge clk_sys_i)
  begin
    if (underrun_o === 1'b1)
      n_under++;
    if (frame_done_o === 1'b1)
      n_done++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  function automatic logic flag(input int w);
    case (w)
      0: return rec_ready_o;
      1: return coded_ready_o;
      2: return busy_o;
      default: return smp_stb_i;
    endcase
  endfunction : flag
  // bounded wait for a status level, seen at falling edges
  task automatic wait_flag(input int w, input int lim);
    for (int t = 0; t < lim; t++)
    begin
      @(negedge clk_sys_i);
      if (flag(w) === 1'b1)
        return;
    end
    n_fail++;
    $display("ERROR wait %0d timed out", w);
    wrap_up();
  endtask : wait_flag
  // reference turbo encoder and frame builder
  task automatic build_exp(input logic [2:0] v, input logic r);
    logic [2:0] st1, st2, sym;
    logic a1, a2;
    int sel, k;
    logic signed [15:0] pv;
    st1 = 3'h0;
    st2 = 3'h0;
    sel = 0;
    for (int i = 0; i < 1148; i++)
    begin
      cb[i] = sb[i];
      a1 = sb[i] ^ st1[1] ^ st1[2];
      a2 = sb[il_fn(11'(i))] ^ st2[1] ^ st2[2];
      cb[1154 + i] = a1 ^ st1[0] ^ st1[2];
      cb[2305 + i] = a2 ^ st2[0] ^ st2[2];
      st1 = {st1[1:0], a1};
      st2 = {st2[1:0], a2};
    end
    for (int i = 0; i < 3; i++)
    begin
      cb[1148 + i] = st1[1] ^ st1[2];
      cb[2302 + i] = st1[0] ^ st1[2];
      cb[1151 + i] = st2[1] ^ st2[2];
      cb[3453 + i] = st2[0] ^ st2[2];
      st1 = {st1[1:0], 1'b0};
      st2 = {st2[1:0], 1'b0};
    end
    for (int sl = 0; sl < 10; sl++)
    begin
      for (int m = 0; m < int'(r ? IDUM_SLOT_FR_ROBUST[sl] : IDUM_SLOT_FR_FAST[sl]) * 160; m++)
      begin
        if (IDUM_SLOT_KIND[sl] == IDUM_SYNC)
        begin
          kq.push_back(2'h3);
          expq.push_back(m < 64 ? 16'sh0000 : sync_fn(11'(928 + m)));
        end
        else if (IDUM_SLOT_KIND[sl] == IDUM_MUTE)
        begin
          kq.push_back(2'h0);
          expq.push_back(16'sh0000);
        end
        else
        begin
          if (m % (r ? 32 : 16) == 0)
          begin
            sym = {cb[rv_fn(v, 11'(sel))], cb[rv_fn(v, 11'(sel + 1))], cb[rv_fn(v, 11'(sel + 2))]};
            sel += 3;
            k = (sym[2] ? 7 - int'(sym) : int'(sym)) * (r ? 8 : 4);
          end
          // robust pulse parameter is left all zero here
          pv = r ? 16'sh0000 : IDUM_PULSE_FAST[(m - k) & 15];
          kq.push_back(sl == 1 ? 2'h1 : 2'h2);
          expq.push_back(sym[2] ? -pv : pv);
        end
      end
    end
  endtask : build_exp
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 1148; i++)
    begin
      rec[i] = 1'($random(seed));
      scr[i] = 1'($random(seed));
      sb[i] = rec[i] ^ scr[i];
    end
    check("pulse_peak", IDUM_PULSE_FAST[9], 16'h3A98);
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    wait_flag(0, 10);
    @(posedge clk_sys_i);
    en <= 1'b1;
    // record bits back to back, then refused extras
    for (int i = 0; i < 1152; i++)
    begin
      rec_valid_i <= 1'b1;
      rec_bit_i <= i < 1148 ? rec[i] : ~rec[i - 4];
      scr_bit_i <= i < 1148 ? scr[i] : 1'b1;
      @(posedge clk_sys_i);
    end
    rec_valid_i <= 1'b0;
    en <= 1'b0;
    wait_flag(1, 10000);
    // fast frame, then robust frame from the same coded buffer
    for (int f = 0; f < 2; f++)
    begin
      rv_i <= 3'($random(seed));
      robust_i <= 1'(f);
      @(posedge clk_sys_i);
      expq.delete();
      kq.delete();
      build_exp(rv_i, 1'(f));
      // start held three edges: the later ones fall while busy
      start_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      start_i <= 1'b0;
      wait_flag(2, 10);
      repeat (20) @(posedge clk_sys_i);
      en <= 1'b1;
      for (int n = 0; n < expq.size(); n++)
      begin
        wait_flag(3, 40);
        @(negedge clk_sys_i);
        case (kq[n])
          2'h0: check("mute", sample_o, expq[n]);
          2'h1: check("data", sample_o, expq[n]);
          2'h2: check("data", sample_o, expq[n]);
          default: check("sync", sample_o, expq[n]);
        endcase
      end
      wait_flag(1, 200);
      en <= 1'b0;
    end
    check("frame_done", 16'(n_done), 16'h0002);
    check("underrun", 16'(n_under), 16'h0000);
    check("busy", {15'h0000, busy_o}, 16'h0000);
    wrap_up();
  end
endmodule : incident_data_uplink_modulator_bench
`default_nettype wire
